// file: hdl/nbc_pkg.sv
/*
  package for the nibble to 5b code-group converter: code-group values,
  data map, state encodings and carrier structs.
  assumes: one symbol clock, nothing outside the codec and its testbench needs these.
*/
package nbc_pkg;

  // ----------------------------------------------------------------
  // code-group values
  // ----------------------------------------------------------------
  localparam logic [4:0] NBC_CG_IDLE = 5'h1f;  // /I/ 11111
  localparam logic [4:0] NBC_CG_J    = 5'h18;  // /J/ 11000
  localparam logic [4:0] NBC_CG_K    = 5'h11;  // /K/ 10001
  localparam logic [4:0] NBC_CG_T    = 5'h0d;  // /T/ 01101
  localparam logic [4:0] NBC_CG_R    = 5'h07;  // /R/ 00111
  localparam logic [4:0] NBC_CG_H    = 5'h04;  // /H/ 00100
  localparam logic [3:0] NBC_SSD_NIB = 4'h5;   // nibble for J and K

  // data nibble 0..f to code group, index = nibble
  localparam logic [4:0] NBC_DATA_MAP [16] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

  // ----------------------------------------------------------------
  // transmit and receive states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    NBC_TX_IDLE = 6'h01,
    NBC_TX_J    = 6'h02,
    NBC_TX_K    = 6'h04,
    NBC_TX_DATA = 6'h08,
    NBC_TX_T    = 6'h10,
    NBC_TX_R    = 6'h20
  } nbc_tx_state_t;

  typedef enum logic [3:0] {
    NBC_RX_IDLE  = 4'h1,
    NBC_RX_GOT_J = 4'h2,
    NBC_RX_FRAME = 4'h4,
    NBC_RX_GOT_T = 4'h8
  } nbc_rx_state_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] nib;
  } nbc_tx_mii_t;

  typedef struct packed {
    logic       crs;
    logic       dv;
    logic       er;
    logic [3:0] nib;
  } nbc_rx_mii_t;

endpackage

// file: hdl/nbc_decode.sv
/*
  5b code group to nibble lookup, combinational.
  assumes: caller interprets control groups itself.
*/
`timescale 1ns/1ps
module nbc_decode
  import nbc_pkg::*;
(
  input  wire logic [4:0] i_cg,
  output logic      [3:0] o_nib,
  output logic            o_is_data
);

  // ----------------------------------------------------------------
  // reverse search of the data map
  // ----------------------------------------------------------------
  always_comb
  begin
    o_nib     = 4'h0;
    o_is_data = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      if (NBC_DATA_MAP[i] == i_cg)
      begin
        o_nib     = 4'(i);
        o_is_data = 1'b1;
      end
    end
  end

endmodule

// file: hdl/nbc_codec.sv
/*
  4b/5b transmit encoder and 5b/4b receive decoder with bypass.
  assumes: tx nibbles and rx code groups arrive already aligned,
  one per i_core_clk; scrambling and serialising happen elsewhere.
*/
`timescale 1ns/1ps

// Overview of operation
// - each tx nibble becomes one code group
// - nibbles 0-7 use the fixed code map
// - nibbles 8-f use the fixed code map
// - no non-data group but H is sent for data
// - idle 11111 sent after end, decoded idle
// - enable rise sends J K, fall T R
// - tx error sends H instead of data
// - J raises carrier only after idle
// - K decodes 0101 only after J
// - T followed by R drops carrier
// - R after T drops carrier, else error
// - invalid groups flag error during valid
// - bypass passes nibble, fifth bit is error
// - J K raises valid, T R or idles drop
module nbc_codec
  import nbc_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_encode_en,   // high = code, low = bypass
  input  wire nbc_tx_mii_t i_tx,          // nibble stream from mac
  output logic       [4:0] o_tx_cg,       // code group toward scrambler
  input  wire logic  [4:0] i_rx_cg,       // aligned code group from line
  output nbc_rx_mii_t      o_rx           // nibble stream to mac
);

  // ----------------------------------------------------------------
  // transmit state
  // ----------------------------------------------------------------
  nbc_tx_state_t tx_state_r, tx_state_nxt;  // sequence position
  logic [4:0]    tx_cg_r,    tx_cg_nxt;     // registered output group

  // data code lookup, used once below
  function automatic logic [4:0] nbc_enc(input logic [3:0] nib, input logic er);
    nbc_enc = er ? NBC_CG_H : NBC_DATA_MAP[nib];
  endfunction

  // next transmit group; the first data nibble coincides with J, so the
  // mac preamble nibbles under J K are consumed and replaced (as in phys)
  always_comb
  begin
    tx_state_nxt = tx_state_r;
    tx_cg_nxt    = NBC_CG_IDLE;
    if (!i_encode_en)
    begin
      tx_cg_nxt    = {i_tx.er, i_tx.nib};
      tx_state_nxt = i_tx.en ? NBC_TX_DATA : NBC_TX_IDLE;
    end
    else
    begin
      case (tx_state_r)
        NBC_TX_IDLE:
        begin
          if (i_tx.en)
          begin
            tx_cg_nxt    = NBC_CG_J;
            tx_state_nxt = NBC_TX_J;
          end
        end
        NBC_TX_J:
        begin
          tx_cg_nxt    = NBC_CG_K;
          tx_state_nxt = i_tx.en ? NBC_TX_K : NBC_TX_T;
        end
        NBC_TX_K, NBC_TX_DATA:
        begin
          if (i_tx.en)
          begin
            tx_cg_nxt    = nbc_enc(i_tx.nib, i_tx.er);
            tx_state_nxt = NBC_TX_DATA;
          end
          else
          begin
            tx_cg_nxt    = NBC_CG_T;
            tx_state_nxt = NBC_TX_T;
          end
        end
        NBC_TX_T:
        begin
          tx_cg_nxt    = NBC_CG_R;
          tx_state_nxt = NBC_TX_R;
        end
        NBC_TX_R:
        begin
          // idle until enable rises again; a new frame may start at once
          tx_cg_nxt    = i_tx.en ? NBC_CG_J : NBC_CG_IDLE;
          tx_state_nxt = i_tx.en ? NBC_TX_J : NBC_TX_IDLE;
        end
        default:
        begin
          tx_state_nxt = NBC_TX_IDLE;
        end
      endcase
    end
  end

  // transmit registers; reset gives idle groups at once
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tx_state_r <= NBC_TX_IDLE;
      tx_cg_r    <= NBC_CG_IDLE;
    end
    else
    begin
      tx_state_r <= tx_state_nxt;
      tx_cg_r    <= tx_cg_nxt;
    end
  end

  assign o_tx_cg = tx_cg_r;

  // ----------------------------------------------------------------
  // receive decode
  // ----------------------------------------------------------------
  logic [3:0]    dec_nib;      // looked-up data nibble
  logic          dec_is_data;  // group is one of the sixteen data groups
  nbc_rx_state_t rx_state_r, rx_state_nxt;
  nbc_rx_mii_t   rx_r,       rx_nxt;
  logic          idle_seen_r, idle_seen_nxt;  // previous group was idle

  nbc_decode u_dec (
    .i_cg      (i_rx_cg),
    .o_nib     (dec_nib),
    .o_is_data (dec_is_data)
  );

  // next receive outputs; while coding, control groups never reach the data lanes
  always_comb
  begin
    rx_state_nxt  = rx_state_r;
    rx_nxt        = '0;
    idle_seen_nxt = (i_rx_cg == NBC_CG_IDLE);
    if (!i_encode_en)
    begin
      // bypass: raw low four bits with the mac framing left to tx
      rx_nxt.nib   = i_rx_cg[3:0];
      rx_nxt.er    = i_rx_cg[4];
      rx_state_nxt = NBC_RX_IDLE;
    end
    else
    begin
      case (rx_state_r)
        NBC_RX_IDLE:
        begin
          if (i_rx_cg == NBC_CG_J && idle_seen_r)
          begin
            rx_state_nxt = NBC_RX_GOT_J;
            rx_nxt.crs   = 1'b1;
          end
          else if (i_rx_cg == NBC_CG_K || i_rx_cg == NBC_CG_T || i_rx_cg == NBC_CG_R ||
                   (i_rx_cg == NBC_CG_J && !idle_seen_r))
          begin
            rx_nxt.er = 1'b1;
          end
        end
        NBC_RX_GOT_J:
        begin
          if (i_rx_cg == NBC_CG_K)
          begin
            // the J K pair goes out as one 0101 preamble nibble with valid
            rx_state_nxt = NBC_RX_FRAME;
            rx_nxt.dv    = 1'b1;
            rx_nxt.crs   = 1'b1;
            rx_nxt.nib   = NBC_SSD_NIB;
          end
          else
          begin
            rx_state_nxt = NBC_RX_IDLE;  // false start
            rx_nxt.er    = 1'b1;
          end
        end
        NBC_RX_FRAME:
        begin
          rx_nxt.crs = 1'b1;
          rx_nxt.dv  = 1'b1;
          if (dec_is_data)
          begin
            rx_nxt.nib = dec_nib;
          end
          else if (i_rx_cg == NBC_CG_T)
          begin
            rx_state_nxt = NBC_RX_GOT_T;  // wait for R before dropping
            rx_nxt.dv    = 1'b0;
          end
          else if (i_rx_cg == NBC_CG_IDLE && idle_seen_r)
          begin
            rx_state_nxt = NBC_RX_IDLE;
            rx_nxt       = '0;
          end
          else
          begin
            rx_nxt.er = 1'b1;
          end
        end
        NBC_RX_GOT_T:
        begin
          rx_state_nxt = NBC_RX_IDLE;
          if (i_rx_cg != NBC_CG_R)
          begin
            rx_nxt.er = 1'b1;
          end
          // otherwise carrier falls cleanly; valid already fell on T
        end
        default:
        begin
          rx_state_nxt = NBC_RX_IDLE;
        end
      endcase
    end
  end

  // receive registers; outputs idle after reset
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_state_r  <= NBC_RX_IDLE;
      rx_r        <= '0;
      idle_seen_r <= 1'b0;
    end
    else
    begin
      rx_state_r  <= rx_state_nxt;
      rx_r        <= rx_nxt;
      idle_seen_r <= idle_seen_nxt;
    end
  end

  assign o_rx = rx_r;

endmodule

// file: testbench/nbc_codec_monitor.sv
/* checker for nbc_codec port behaviour.
   assumes: bound onto every nbc_codec, one symbol clock. */
`timescale 1ns/1ps
module nbc_codec_monitor
  import nbc_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_encode_en,
  input wire nbc_tx_mii_t i_tx,
  input wire logic  [4:0] o_tx_cg,
  input wire logic  [4:0] i_rx_cg,
  input wire nbc_rx_mii_t o_rx
);
  // ----
  // properties, encode checks need coding on for the cycles they span
  // ----
  default clocking dck @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // a J still showing means enable came back right after T R, so K is owed first
  chk_data_map: assert property ((i_encode_en && i_tx.en)[*3] ##0 (!i_tx.er && o_tx_cg != NBC_CG_J)
    |=> o_tx_cg == NBC_DATA_MAP[$past(i_tx.nib)]) else $error("wrong data group");
  chk_err_sym: assert property ((i_encode_en && i_tx.en)[*3] ##0 (i_tx.er && o_tx_cg != NBC_CG_J)
    |=> o_tx_cg == NBC_CG_H) else $error("no error symbol");
  chk_start_j: assert property (i_encode_en[*2] ##0 (i_tx.en && o_tx_cg == NBC_CG_IDLE)
    |=> o_tx_cg == NBC_CG_J) else $error("no start group");
  chk_j_then_k: assert property (i_encode_en[*2] ##0 o_tx_cg == NBC_CG_J
    |=> o_tx_cg == NBC_CG_K) else $error("no second start group");
  chk_end_tr: assert property ((i_encode_en && i_tx.en)[*3] ##1 (i_encode_en && !i_tx.en)
    |=> o_tx_cg == NBC_CG_T ##1 o_tx_cg == NBC_CG_R) else $error("no end pair");
  chk_bypass_tx: assert property (!i_encode_en
    |=> o_tx_cg == $past(i_tx[4:0])) else $error("bypass group wrong");
  chk_rx_ssd: assert property (i_encode_en && o_rx.crs && !o_rx.dv && i_rx_cg == NBC_CG_K
    && $past(i_rx_cg) == NBC_CG_J |=> o_rx.dv && o_rx.nib == NBC_SSD_NIB) else $error("start not taken");
  chk_rx_bad: assert property (i_encode_en && o_rx.dv && (i_rx_cg == 5'h00 || i_rx_cg == NBC_CG_J)
    |=> o_rx.er) else $error("bad group not flagged");
endmodule
bind nbc_codec nbc_codec_monitor u_mon (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_encode_en(i_encode_en),
  .i_tx(i_tx), .o_tx_cg(o_tx_cg), .i_rx_cg(i_rx_cg), .o_rx(o_rx));

// file: testbench/nbc_mac_model.sv
/* mac side transmit model: presents one frame of counting nibbles.
   assumes: i_go pulses only while no frame runs. */
`timescale 1ns/1ps
module nbc_mac_model
  import nbc_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_go,      // start a frame
  input  wire logic  [7:0] i_len,     // nibbles in the frame
  input  wire logic  [7:0] i_err_at,  // index carrying tx error
  input  wire logic  [3:0] i_base,    // value of nibble 0
  output nbc_tx_mii_t      o_tx
);
  // ----
  // frame sequencer
  // ----
  logic [7:0] idx_r;  // index plus one, zero while idle
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      idx_r <= 8'h00;
    else if (i_go)
      idx_r <= 8'h01;
    else if (idx_r != 8'h00 && idx_r < i_len)
      idx_r <= idx_r + 8'h01;
    else
      idx_r <= 8'h00;
  end
  // idle data lines carry inverted base so a stale nibble never looks right
  always_comb
  begin
    o_tx.en  = idx_r != 8'h00;
    o_tx.er  = o_tx.en && (idx_r - 8'h01 == i_err_at);
    o_tx.nib = o_tx.en ? i_base + 4'(idx_r - 8'h01) : ~i_base;
  end
endmodule

// file: testbench/tb_nibble_to_5b_codec.sv
/* loopback bench for nbc_codec: tx code groups feed rx.
   assumes: nbc_mac_model drives tx; the checker binds itself. */
`timescale 1ns/1ps
module tb_nibble_to_5b_codec
  import nbc_pkg::*;
;
  // ----
  // signals
  // ----
  logic        i_core_clk = 1'b0;
  logic        i_rst      = 1'b1;
  logic        enc_en     = 1'b1;
  logic        go         = 1'b0;
  logic        inj        = 1'b0;  // swaps the looped group for bad_cg
  logic  [4:0] bad_cg     = 5'h00;
  logic  [7:0] len        = 8'h08;
  logic  [7:0] err_at     = 8'hff;
  logic  [3:0] base       = 4'h0;
  logic [31:0] seed       = 32'h1bf4ff49;
  logic  [7:0] exp_tx;
  logic  [7:0] exp_rx;
  logic        er_seen    = 1'b0;
  logic  [3:0] got_q[$];
  int          err_total  = 0;
  int          cmp_count  = 0;
  nbc_tx_mii_t tx;
  nbc_rx_mii_t rx;
  logic  [4:0] tx_cg;
  // invalid groups, then J K T R out of place, then a lone idle inside a frame
  logic  [4:0] bad_t[15]  = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19,
                              5'h18, 5'h11, 5'h0d, 5'h07, 5'h1f};
  always #12.5 i_core_clk = ~i_core_clk;
  nbc_mac_model mac (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_go(go), .i_len(len), .i_err_at(err_at),
                     .i_base(base), .o_tx(tx));
  nbc_codec dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_encode_en(enc_en), .i_tx(tx), .o_tx_cg(tx_cg),
                 .i_rx_cg(inj ? bad_cg : tx_cg), .o_rx(rx));
  // collect delivered nibbles and any receive error
  always @(posedge i_core_clk)
  begin
    if (rx.dv === 1'b1)
      got_q.push_back(rx.nib);
    if (rx.er === 1'b1)
      er_seen = 1'b1;
  end
  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction
  // first delivered nibble is the start pair, then data from index 2
  function automatic logic [3:0] exp_nib(input int i);
    exp_nib = (i == 0) ? NBC_SSD_NIB : base + 4'(i + 1);
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("cmp_count=%0d err_total=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one frame; at > 0 injects bad_cg that many cycles after start
  task automatic frame(input logic [7:0] n, input logic [7:0] e, input int at);
    got_q = {};
    er_seen = 1'b0;
    len <= n;
    err_at <= e;
    base <= seed[3:0];
    go <= 1'b1;
    @(posedge i_core_clk);
    go <= 1'b0;
    if (at > 0)
    begin
      repeat (at) @(posedge i_core_clk);
      inj <= 1'b1;
      @(posedge i_core_clk);
      inj <= 1'b0;
    end
    repeat (32'(n) + 12) @(posedge i_core_clk);
    if (at > 0 || e != 8'hff)
      cmp(8'(er_seen), 8'h01);
    else
    begin
      cmp(8'(got_q.size()), n - 8'h01);
      foreach (got_q[i])
        cmp(8'(got_q[i]), 8'(exp_nib(i)));
      cmp(8'(er_seen), 8'h00);
    end
    cmp(8'(tx_cg), 8'(NBC_CG_IDLE));
    cmp(8'(rx), 8'h00);
    $display("frame done len=%0d", n);
  endtask
  // ----
  // sequence and watchdog
  // ----
  initial
  begin
    repeat (20) @(posedge i_core_clk);
    cmp(8'(tx_cg), 8'(NBC_CG_IDLE));
    cmp(8'(rx), 8'h00);
    i_rst <= 1'b0;
    frame(8'h03, 8'hff, 0);
    for (int k = 0; k < 12; k++)
    begin
      seed = lfsr(seed);
      frame(8'h03 + 8'(seed[12:8]), 8'hff, 0);
    end
    frame(8'h0a, 8'h05, 0);
    foreach (bad_t[j])
    begin
      bad_cg <= bad_t[j];
      frame(8'h0c, 8'hff, 6);
    end
    enc_en <= 1'b0;
    go <= 1'b1;
    err_at <= 8'h03;
    @(posedge i_core_clk);
    go <= 1'b0;
    repeat (10)
    begin
      @(posedge i_core_clk);
      exp_tx = 8'(tx[4:0]);
      exp_rx = 8'(tx_cg);
      #1;
      cmp(8'(tx_cg), exp_tx);
      cmp(8'(rx), exp_rx);
    end
    $display("bypass done");
    @(posedge i_core_clk);
    enc_en <= 1'b1;
    // the bypass frame tail ends as a stray T R, flagged for several cycles
    repeat (8) @(posedge i_core_clk);
    frame(8'h10, 8'hff, 0);
    final_report();
  end
  initial
  begin
    repeat (5000) @(posedge i_core_clk);
    err_total++;
    final_report();
  end
endmodule
